/* bench/ccrc_chk_sva.sv */
// checker on the run/enable control ports
// assumes bind into ccrc_top with the same clear count
module ccrc_chk #(parameter CLR_CYCLES = 1) (
	input wire        clk, reset_n, ce, reg_wr, dp_idle, cpl_flush_done,
	input wire        cmd_fetch_en, cpl_post_en, cpl_flush_req, io_queue_clear, admin_queue_reset, ready_status_bit,
	input wire [5:0]  reg_addr,
	input wire [31:0] controller_configuration, admin_queue_attributes,
	input wire [63:0] admin_sq_base, admin_cq_base);
	wire run = controller_configuration[0];
	wire rdy = ready_status_bit;
	wire clr = io_queue_clear;
	reg [3:0] clr_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// run length of the clear pulse
	always @(posedge clk or negedge reset_n) if (!reset_n) clr_n <= 4'h0; else clr_n <= clr ? clr_n + 4'h1 : 4'h0;
	AST_RUN_GATE: assert property (cmd_fetch_en |-> run && rdy) else $error("fetch early");
	AST_STOP_GATE: assert property (!run |-> !cmd_fetch_en && !cpl_post_en) else $error("busy stopped");
	AST_FALL_FLUSH: assert property ($fell(run) && rdy |=> cpl_flush_req) else $error("no flush");
	AST_CLR_CAUSE: assert property ($rose(clr) |-> $past(cpl_flush_req && dp_idle && cpl_flush_done)
		&& admin_queue_reset) else $error("early clear");
	AST_CLR_LEN: assert property ($fell(clr) |-> clr_n == CLR_CYCLES + 1) else $error("clear length");
	AST_ADMIN_KEEP: assert property (clr && !reg_wr |=> $stable(admin_queue_attributes) && $stable(admin_sq_base)
		&& $stable(admin_cq_base)) else $error("admin lost");
	AST_IDLE_ENTRY: assert property ($fell(clr) |-> controller_configuration[31:1] == 31'h0 && !rdy)
		else $error("idle entry");
	AST_READY_DROP: assert property ($fell(run) && rdy |-> ##[1:40] !rdy) else $error("ready stuck");
	AST_ADMIN_LOCK: assert property (ce && reg_wr && run && reg_addr == 6'h24 |=> $stable(admin_queue_attributes))
		else $error("admin taken");
	cover property ($rose(rdy));
	cover property ($fell(clr));
	cover property (reg_wr && run && reg_addr == 6'h24);
endmodule

/* bench/ccrc_dp_model.sv */
// datapath model: idle while fetch is off, flush confirmed after a set lag
// assumes the flush request is a level held until confirmed
module ccrc_dp_model (
	input wire        clk, cmd_fetch_en, cpl_flush_req,
	input wire [3:0]  lag,
	output wire       dp_idle, cpl_flush_done);
	timeunit 1ns;
	timeprecision 1ps;
	reg [3:0] n = 4'h0;
	always @(posedge clk) n <= cpl_flush_req ? n + {3'h0, n != 4'hf} : 4'h0;
	assign dp_idle = !cmd_fetch_en;
	// lag of zero answers at once, larger lags stall the flush
	assign cpl_flush_done = cpl_flush_req && n >= lag;
endmodule

/* bench/ccrc_top_tb.sv */
// bench for the run/enable control: register calls with expected values
// assumes 40 MHz clock and shortened start and clear counts
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %h got %h", n, e, g); end end
module ccrc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, reset_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, dp_idle, cpl_flush_done, cmd_fetch_en;
	logic        cpl_post_en, cpl_flush_req, io_queue_clear, admin_queue_reset, ready_status_bit;
	logic [5:0]  reg_addr = 0;
	logic [3:0]  lag = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, controller_configuration, admin_queue_attributes;
	logic [63:0] admin_sq_base, admin_cq_base;
	int          fails = 0, checked = 0;
	always #12.5 clk = ~clk;
	ccrc_top #(.START_CYCLES(2), .CLR_CYCLES(1)) uut (.*);
	ccrc_dp_model dp (.*);
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge clk) reg_wr = 0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		@(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
		@(negedge clk) reg_rd = 0;
		`CHK("rdata", e, reg_rdata)
	endtask
	task automatic wait_rdy(input logic v);
		for (int i = 0; i < 60 && ready_status_bit !== v; i++) @(negedge clk);
		`CHK("ready", v, ready_status_bit)
	endtask
	task final_report;
		$display("fails %0d checked %0d", fails, checked);
		if (fails == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge clk);
		reset_n = 1;
		repeat (3) @(negedge clk);
		rd(6'h14, 0);
		rd(6'h1c, 0);
		rd(6'h3c, 0);
		wr(6'h24, 32'h001f_001f);
		wr(6'h28, 32'h1000);
		rd(6'h24, 32'h001f_001f);
		$display("test reset done");
		// second pass stalls the flush
		for (int k = 0; k < 2; k++) begin
			lag = k ? 4'h6 : 4'h0;
			wr(6'h14, 32'h0046_0001);
			wait_rdy(1);
			`CHK("fetch", 1'b1, cmd_fetch_en)
			rd(6'h1c, 1);
			ce = 0;
			wr(6'h14, 0);
			ce = 1;
			`CHK("frozen", 32'h0046_0001, controller_configuration)
			wr(6'h24, 0);
			wr(6'h14, 32'h0046_0000);
			`CHK("post", 1'b0, cpl_post_en)
			wait_rdy(0);
			rd(6'h14, 0);
			rd(6'h24, 32'h001f_001f);
			`CHK("asq", 64'h1000, admin_sq_base)
			$display("test cycle %0d done", k);
		end
		final_report;
	end
	initial begin
		#(25 * 4000);
		fails++;
		final_report;
	end
endmodule
bind ccrc_top ccrc_chk #(.CLR_CYCLES(CLR_CYCLES)) chk (.*);

/* hdl/ccrc_regs.vh */
// register offsets, field positions, reset values and counts for the run/enable control
// assumes a simple one-cycle register write/read port from the host-facing register space
`ifndef CCRC_REGS_VH
`define CCRC_REGS_VH

`define CCRC_OFF_CFG      6'h14
`define CCRC_OFF_STATUS   6'h1c
`define CCRC_OFF_AQA      6'h24
`define CCRC_OFF_ASQ_LO   6'h28
`define CCRC_OFF_ASQ_HI   6'h2c
`define CCRC_OFF_ACQ_LO   6'h30
`define CCRC_OFF_ACQ_HI   6'h34

`define CCRC_RUN_BIT      0
`define CCRC_READY_BIT    0
`define CCRC_CFG_RST      32'h0000_0000
`define CCRC_STATUS_RST   32'h0000_0000
`define CCRC_ADMIN_RST    32'h0000_0000

`define CCRC_START_CYCLES 16
`define CCRC_CLR_CYCLES   4

`endif

/* hdl/ccrc_rst_sync.v */
// two-stage release synchroniser for the asynchronous low-active reset
// assumes reset_n may drop at any time and rises asynchronously to clk
module ccrc_rst_sync (
	// clock and raw reset
	input  wire clk,
	input  wire reset_n,
	// synchronised reset
	output wire rst_sync_n
);
	reg meta_r;
	reg sync_r;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= 1'b1;
			sync_r <= meta_r;
		end
	end

	assign rst_sync_n = sync_r;
endmodule

/* hdl/ccrc_top.v */
// run/enable control of a storage controller: configuration, status, admin queue setup registers
// assumes host writes arrive as single-cycle strobes; datapath reports idle and flush completion
`include "ccrc_regs.vh"
module ccrc_top #(
	parameter START_CYCLES = `CCRC_START_CYCLES,
	parameter CLR_CYCLES   = `CCRC_CLR_CYCLES
) (
	// clock, reset, enable
	input  wire        clk,
	input  wire        reset_n,
	input  wire        ce,
	// register port
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [5:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	output reg  [31:0] reg_rdata,
	// datapath handshake
	input  wire        dp_idle,
	input  wire        cpl_flush_done,
	output wire        cmd_fetch_en,
	output wire        cpl_post_en,
	output wire        cpl_flush_req,
	output wire        io_queue_clear,
	output wire        admin_queue_reset,
	// register views
	output wire        ready_status_bit,
	output wire [31:0] controller_configuration,
	output wire [31:0] admin_queue_attributes,
	output wire [63:0] admin_sq_base,
	output wire [63:0] admin_cq_base
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_START = 3'h1;
	localparam ST_RUN   = 3'h2;
	localparam ST_FLUSH = 3'h3;
	localparam ST_CLEAR = 3'h4;
	localparam [31:0] CFG_RST = `CCRC_CFG_RST;

	wire        rst_n;
	reg  [2:0]  state_r;
	reg  [2:0]  state_nxt;
	reg  [15:0] cnt_r;
	reg  [15:0] cnt_nxt;
	reg         run_prev_r;
	reg         ready_r;
	reg  [31:0] cfg_r;
	reg  [31:0] aqa_r;
	reg  [63:0] asq_r;
	reg  [63:0] acq_r;
	wire        run;
	wire        run_fall;
	wire        run_rise;
	wire        ctrl_reset;
	wire        in_run;
	wire        in_flush;
	wire        wr_cfg;
	wire        wr_aqa;
	wire        wr_asq_lo;
	wire        wr_asq_hi;
	wire        wr_acq_lo;
	wire        wr_acq_hi;

	ccrc_rst_sync u_rst_sync (
		.clk        (clk),
		.reset_n    (reset_n),
		.rst_sync_n (rst_n)
	);

	assign run      = cfg_r[`CCRC_RUN_BIT];
	assign run_fall = run_prev_r & ~run;
	assign run_rise = ~run_prev_r & run;

	// decoded state and write strobes, ce folded in so frozen cycles take nothing
	assign in_run    = (state_r == ST_RUN);
	assign in_flush  = (state_r == ST_FLUSH);
	assign wr_cfg    = ce & reg_wr & (reg_addr == `CCRC_OFF_CFG);
	// admin setup locked while running, host writes then are dropped
	assign wr_aqa    = ce & reg_wr & ~run & (reg_addr == `CCRC_OFF_AQA);
	assign wr_asq_lo = ce & reg_wr & ~run & (reg_addr == `CCRC_OFF_ASQ_LO);
	assign wr_asq_hi = ce & reg_wr & ~run & (reg_addr == `CCRC_OFF_ASQ_HI);
	assign wr_acq_lo = ce & reg_wr & ~run & (reg_addr == `CCRC_OFF_ACQ_LO);
	assign wr_acq_hi = ce & reg_wr & ~run & (reg_addr == `CCRC_OFF_ACQ_HI);

	// run-bit edge history
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_prev_r <= 1'b0;
		end else if (ce) begin
			run_prev_r <= run;
		end
	end

	// sequencer
	always @* begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			ST_IDLE: begin
				if (run_rise) begin
					state_nxt = ST_START;
					cnt_nxt   = START_CYCLES[15:0];
				end
			end
			ST_START: begin
				// no namespace gating, only local bring-up
				if (!run) begin
					state_nxt = ST_FLUSH;
				end else if (cnt_r == 16'h0000) begin
					state_nxt = ST_RUN;
				end else begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end
			ST_RUN: begin
				if (run_fall) begin
					state_nxt = ST_FLUSH;
				end
			end
			ST_FLUSH: begin
				// posted completions must be durable before queues vanish
				if (cpl_flush_done && dp_idle) begin
					state_nxt = ST_CLEAR;
					cnt_nxt   = CLR_CYCLES[15:0];
				end
			end
			ST_CLEAR: begin
				if (cnt_r == 16'h0000) begin
					state_nxt = ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				cnt_nxt   = 16'h0000;
			end
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			cnt_r   <= 16'h0000;
			ready_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			if (state_nxt == ST_RUN) begin
				ready_r <= 1'b1;
			end else if (state_nxt == ST_IDLE) begin
				ready_r <= 1'b0;
			end
		end
	end

	assign ctrl_reset = (state_r == ST_CLEAR);

	// configuration and admin queue setup registers
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= `CCRC_CFG_RST;
			aqa_r <= `CCRC_ADMIN_RST;
			asq_r <= {`CCRC_ADMIN_RST, `CCRC_ADMIN_RST};
			acq_r <= {`CCRC_ADMIN_RST, `CCRC_ADMIN_RST};
		end else if (ce) begin
			if (wr_cfg) begin
				cfg_r <= reg_wdata;
			end else if (ctrl_reset) begin
				cfg_r <= {CFG_RST[31:1], run};
			end
			// admin setup left alone by controller reset
			if (wr_aqa) begin
				aqa_r <= reg_wdata;
			end
			if (wr_asq_lo) begin
				asq_r[31:0] <= reg_wdata;
			end
			if (wr_asq_hi) begin
				asq_r[63:32] <= reg_wdata;
			end
			if (wr_acq_lo) begin
				acq_r[31:0] <= reg_wdata;
			end
			if (wr_acq_hi) begin
				acq_r[63:32] <= reg_wdata;
			end
		end
	end

	// read data registered, one cycle after reg_rd
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else if (ce && reg_rd) begin
			case (reg_addr)
				`CCRC_OFF_CFG:    reg_rdata <= cfg_r;
				`CCRC_OFF_STATUS: reg_rdata <= {31'h0000_0000, ready_r};
				`CCRC_OFF_AQA:    reg_rdata <= aqa_r;
				`CCRC_OFF_ASQ_LO: reg_rdata <= asq_r[31:0];
				`CCRC_OFF_ASQ_HI: reg_rdata <= asq_r[63:32];
				`CCRC_OFF_ACQ_LO: reg_rdata <= acq_r[31:0];
				`CCRC_OFF_ACQ_HI: reg_rdata <= acq_r[63:32];
				default:          reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// gating towards the command datapath
	assign cmd_fetch_en      = run & in_run;
	assign cpl_post_en       = run & in_run;
	assign cpl_flush_req     = in_flush;
	assign io_queue_clear    = ctrl_reset;
	assign admin_queue_reset = ctrl_reset;
	// bring-up only after the host saw ready low, else undefined
	assign ready_status_bit         = ready_r;
	assign controller_configuration = cfg_r;
	assign admin_queue_attributes   = aqa_r;
	assign admin_sq_base            = asq_r;
	assign admin_cq_base            = acq_r;
endmodule
